// [mmd_map.svh]
// constants for the program and data memory map decoder
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH

// address widths
`define PC_W 21
`define DADDR_W 12

// program space landmarks
`define RESET_VEC 21'h000000
`define INT_VEC_HI 21'h000008
`define INT_VEC_LO 21'h000018
`define BOOT_LAST 21'h0007ff
`define FLASH_LAST_48K 21'h00bfff
`define FLASH_LAST_64K 21'h00ffff
`define INSTR_STEP 21'h000002

// data space landmarks
`define SFR_BASE 12'hf60
`define LAST_BANK 4'hf
`define FIRST_BANK 4'h0

// register byte offsets on the wishbone slave
`define REG_BANK_SEL 8'h00
`define REG_MODE_STAT 8'h04
`define REG_TBL_PTR 8'h08
`define REG_TBL_LATCH 8'h0c
`define REG_IND_PTR0 8'h10

// reset values
`define BANK_SEL_RST 4'h0
`define TBL_PTR_RST 21'h000000
`define TBL_LATCH_RST 8'h00
`define IND_PTR_RST 12'h000

`endif

// [mmd_pkg.sv]
// types shared by the memory map decoder
package mmd_pkg;

  typedef enum logic [1:0] {
    external_only_mode,
    boot_block_mode,
    extended_internal_external_mode,
    internal_only_mode
  } prog_mode_t;

  typedef enum logic [1:0] {
    route_internal,
    route_external,
    route_zero
  } route_t;

  typedef enum logic {
    move_idle,
    move_write
  } move_state_t;

endpackage

// [mem_map_decoder.sv]
// program and data memory map decoder with wishbone register slave
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`include "mmd_map.svh"

module mem_map_decoder
  import mmd_pkg::*;
#(
  parameter int FLASH_KBYTES = 64,
  parameter bit HAS_EXT_BUS = 1'b1,
  parameter logic [1:0] CODE_EXT_ONLY = 2'b00,
  parameter logic [1:0] CODE_BOOT_BLOCK = 2'b01,
  parameter logic [1:0] CODE_EXTENDED = 2'b10,
  parameter logic [1:0] CODE_INTERNAL = 2'b11,
  parameter logic [7:0] ACCESS_SPLIT = 8'h60,
  parameter int GPR_BYTES = 3936,
  parameter int NUM_PTR = 3
) (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // configuration
  input wire logic [1:0] i_mode_cfg,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // core fetch control
  input wire logic i_fetch_step,
  input wire logic i_pc_load,
  input wire logic [`PC_W-1:0] i_pc_value,
  input wire logic i_int_hi,
  input wire logic i_int_lo,
  output logic [`PC_W-1:0] o_pc,
  output logic [15:0] o_instr,
  output logic o_instr_valid,
  // internal flash port
  output logic o_int_req,
  output logic [`PC_W-1:0] o_int_addr,
  input wire logic [15:0] i_int_rdata,
  // external program memory port
  output logic o_ext_req,
  output logic [`PC_W-1:0] o_ext_addr,
  input wire logic [15:0] i_ext_rdata,
  // table transfers
  input wire logic i_tbl_rd,
  input wire logic i_tbl_wr,
  output logic o_prog_wr,
  output logic [`PC_W-1:0] o_prog_wr_addr,
  output logic [7:0] o_prog_wr_byte,
  // data memory access
  input wire logic i_dm_req,
  input wire logic i_dm_we,
  input wire logic i_dm_indirect,
  input wire logic [1:0] i_dm_ptr_sel,
  input wire logic i_dm_use_access,
  input wire logic [7:0] i_dm_offset,
  input wire logic [7:0] i_dm_wdata,
  output logic [7:0] o_dm_rdata,
  // register to register move
  input wire logic i_move_req,
  input wire logic [`DADDR_W-1:0] i_move_src,
  input wire logic [`DADDR_W-1:0] i_move_dst,
  output logic o_move_busy,
  // special function register port
  output logic o_sfr_req,
  output logic o_sfr_we,
  output logic [`DADDR_W-1:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata,
  input wire logic [7:0] i_sfr_rdata
);

  if (FLASH_KBYTES != 48 && FLASH_KBYTES != 64) begin : g_bad_flash
    $error("flash size must be 48 or 64 kilobytes");
  end
  if (GPR_BYTES < 1 || GPR_BYTES > 'hf60) begin : g_bad_gpr
    $error("general register bytes must fit below the special registers");
  end
  if (NUM_PTR < 1 || NUM_PTR > 4) begin : g_bad_ptr
    $error("indirect pointer count must be 1 to 4");
  end
  if (CODE_EXT_ONLY == CODE_BOOT_BLOCK || CODE_EXT_ONLY == CODE_EXTENDED ||
      CODE_EXT_ONLY == CODE_INTERNAL || CODE_BOOT_BLOCK == CODE_EXTENDED ||
      CODE_BOOT_BLOCK == CODE_INTERNAL || CODE_EXTENDED == CODE_INTERNAL) begin : g_bad_code
    $error("mode codes must be distinct");
  end

  localparam logic [`PC_W-1:0] FLASH_LAST = (FLASH_KBYTES == 48) ? `FLASH_LAST_48K : `FLASH_LAST_64K;
  localparam logic [`DADDR_W-1:0] GPR_LIMIT = 12'(GPR_BYTES);
  localparam logic [5:0] PTR_LIMIT = 6'(NUM_PTR);

  // ---------------- functions
  function automatic prog_mode_t decode_mode(input logic [1:0] code);
    prog_mode_t m;
    m = internal_only_mode;
    if (code == CODE_EXT_ONLY) m = external_only_mode;
    if (code == CODE_BOOT_BLOCK) m = boot_block_mode;
    if (code == CODE_EXTENDED) m = extended_internal_external_mode;
    return m;
  endfunction

  function automatic route_t route_of(input logic [`PC_W-1:0] a, input prog_mode_t m);
    route_t r;
    unique case (m)
      external_only_mode: r = route_external;
      boot_block_mode: r = (a <= `BOOT_LAST) ? route_internal : route_external;
      extended_internal_external_mode: r = (a <= FLASH_LAST) ? route_internal : route_external;
      internal_only_mode: r = (a <= FLASH_LAST) ? route_internal : route_zero;
    endcase
    return r;
  endfunction

  function automatic logic [`DADDR_W-1:0] direct_addr(input logic [7:0] off, input logic use_acc,
                                                     input logic [3:0] bank);
    logic [3:0] b;
    b = bank;
    if (use_acc) b = (off < ACCESS_SPLIT) ? `FIRST_BANK : `LAST_BANK;
    return {b, off};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // ---------------- configuration and mode
  logic [1:0] cfg_q;
  prog_mode_t eff_mode;

  // the configuration byte is nonvolatile, so it is sampled while reset is held
  always_ff @(posedge i_core_clk) begin
    if (i_srst) cfg_q <= i_mode_cfg;
  end

  assign eff_mode = HAS_EXT_BUS ? decode_mode(cfg_q) : internal_only_mode;

  // ---------------- registers
  logic [3:0] bank_sel;
  logic [`PC_W-1:0] tbl_ptr;
  logic [7:0] tbl_latch;
  logic [`DADDR_W-1:0] ind_ptr [NUM_PTR];
  logic wb_req;
  logic wb_wr;
  logic [7:0] ptr_rel;
  logic ptr_hit;
  logic [1:0] ptr_slot;
  logic [31:0] wb_rd_value;
  logic [31:0] tbl_ptr_new;

  assign wb_req = i_wb_cyc & i_wb_stb;
  // writes land on the edge where the master sees ack
  assign wb_wr = i_ce & wb_req & o_wb_ack & i_wb_we;
  assign ptr_rel = i_wb_adr - `REG_IND_PTR0;
  assign ptr_hit = (i_wb_adr >= `REG_IND_PTR0) && (ptr_rel[7:2] < PTR_LIMIT) && (ptr_rel[1:0] == 2'b00);
  assign ptr_slot = ptr_rel[3:2];
  assign tbl_ptr_new = merge({11'h0, tbl_ptr}, i_wb_dat, i_wb_sel);
  assign wb_rd_value =
    (i_wb_adr == `REG_BANK_SEL) ? {28'h0000000, bank_sel} :
    (i_wb_adr == `REG_MODE_STAT) ? {29'h0000000, HAS_EXT_BUS, 2'(eff_mode)} :
    (i_wb_adr == `REG_TBL_PTR) ? {11'h0, tbl_ptr} :
    (i_wb_adr == `REG_TBL_LATCH) ? {24'h000000, tbl_latch} :
    ptr_hit ? {20'h00000, ind_ptr[ptr_slot]} : 32'h00000000;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else if (i_ce) begin
      o_wb_ack <= wb_req & ~o_wb_ack;
      if (wb_req & ~o_wb_ack) o_wb_dat <= wb_rd_value;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      bank_sel <= `BANK_SEL_RST;
      tbl_ptr <= `TBL_PTR_RST;
    end else if (wb_wr) begin
      // upper four bank select bits do not exist
      if (i_wb_adr == `REG_BANK_SEL && i_wb_sel[0]) bank_sel <= i_wb_dat[3:0];
      if (i_wb_adr == `REG_TBL_PTR) tbl_ptr <= tbl_ptr_new[`PC_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    for (int i = 0; i < NUM_PTR; i++) begin
      if (i_srst) ind_ptr[i] <= `IND_PTR_RST;
      else if (wb_wr && ptr_hit && ptr_slot == 2'(i))
        ind_ptr[i] <= 12'(merge({20'h00000, ind_ptr[i]}, i_wb_dat, i_wb_sel));
    end
  end

  // ---------------- program side
  logic [`PC_W-1:0] pc;
  logic [`PC_W-1:0] next_pc;
  logic [`PC_W-1:0] prog_addr;
  logic fetch_go;
  logic prog_req;
  route_t prog_route;
  logic [15:0] prog_word;

  // a table read borrows the program bus, so the fetch waits a cycle
  assign fetch_go = i_fetch_step & ~i_tbl_rd;
  assign prog_req = i_ce & (fetch_go | i_tbl_rd);
  assign prog_addr = i_tbl_rd ? {tbl_ptr[`PC_W-1:1], 1'b0} : pc;
  assign prog_route = route_of(prog_addr, eff_mode);
  assign o_int_req = prog_req & (prog_route == route_internal);
  assign o_ext_req = prog_req & (prog_route == route_external);
  assign o_int_addr = prog_addr;
  assign o_ext_addr = prog_addr;
  assign prog_word = (prog_route == route_internal) ? i_int_rdata :
                     (prog_route == route_external) ? i_ext_rdata : 16'h0000;
  assign next_pc = i_int_hi ? `INT_VEC_HI :
                   i_int_lo ? `INT_VEC_LO :
                   i_pc_load ? i_pc_value :
                   fetch_go ? pc + `INSTR_STEP : pc;
  assign o_pc = pc;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) pc <= `RESET_VEC;
    else if (i_ce) pc <= next_pc;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_instr <= 16'h0000;
      o_instr_valid <= 1'b0;
    end else if (i_ce) begin
      o_instr_valid <= fetch_go;
      if (fetch_go) o_instr <= prog_word;
    end
  end

  // even table address is the low byte of the word
  always_ff @(posedge i_core_clk) begin
    if (i_srst) tbl_latch <= `TBL_LATCH_RST;
    else if (i_ce && i_tbl_rd) tbl_latch <= tbl_ptr[0] ? prog_word[15:8] : prog_word[7:0];
    else if (wb_wr && i_wb_adr == `REG_TBL_LATCH && i_wb_sel[0]) tbl_latch <= i_wb_dat[7:0];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_prog_wr <= 1'b0;
      o_prog_wr_addr <= `TBL_PTR_RST;
      o_prog_wr_byte <= `TBL_LATCH_RST;
    end else if (i_ce) begin
      o_prog_wr <= i_tbl_wr;
      if (i_tbl_wr) begin
        o_prog_wr_addr <= tbl_ptr;
        o_prog_wr_byte <= tbl_latch;
      end
    end
  end

  // ---------------- data side, independent of the program mode
  move_state_t move_state;
  logic move_active;
  logic [`DADDR_W-1:0] move_dst_q;
  logic [7:0] move_data;
  logic dm_ptr_ok;
  logic [1:0] ptr_idx;
  logic [`DADDR_W-1:0] dm_addr;
  logic dm_go;
  logic [`DADDR_W-1:0] acc_addr;
  logic acc_we;
  logic acc_rd;
  logic [7:0] acc_wdata;
  logic is_sfr;
  logic is_gpr;
  logic [`DADDR_W-1:0] gpr_idx;
  logic [7:0] rd_value;
  logic [7:0] gpr_ram [GPR_BYTES];

  assign move_active = (move_state == move_write);
  assign o_move_busy = move_active;
  assign dm_ptr_ok = ({4'h0, i_dm_ptr_sel} < PTR_LIMIT);
  assign ptr_idx = dm_ptr_ok ? i_dm_ptr_sel : 2'b00;
  assign dm_addr = i_dm_indirect ? ind_ptr[ptr_idx] : direct_addr(i_dm_offset, i_dm_use_access, bank_sel);
  // a move owns the data port; a missing pointer slot is ignored
  assign dm_go = i_dm_req & ~move_active & ~i_move_req & (~i_dm_indirect | dm_ptr_ok);
  assign acc_addr = move_active ? move_dst_q : (i_move_req ? i_move_src : dm_addr);
  assign acc_we = move_active | (dm_go & i_dm_we);
  assign acc_rd = (i_move_req & ~move_active) | (dm_go & ~i_dm_we);
  assign acc_wdata = move_active ? move_data : i_dm_wdata;
  assign is_sfr = (acc_addr >= `SFR_BASE);
  assign is_gpr = (acc_addr < GPR_LIMIT);
  assign gpr_idx = is_gpr ? acc_addr : 12'h000;
  assign rd_value = is_sfr ? i_sfr_rdata : (is_gpr ? gpr_ram[gpr_idx] : 8'h00);
  assign o_sfr_req = i_ce & (acc_rd | acc_we) & is_sfr;
  assign o_sfr_we = i_ce & acc_we & is_sfr;
  assign o_sfr_addr = acc_addr;
  assign o_sfr_wdata = acc_wdata;

  // no reset branch: contents survive every reset
  always_ff @(posedge i_core_clk) begin
    if (i_ce && acc_we && is_gpr) gpr_ram[gpr_idx] <= acc_wdata;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) o_dm_rdata <= 8'h00;
    else if (i_ce && dm_go && !i_dm_we) o_dm_rdata <= rd_value;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) move_state <= move_idle;
    else if (i_ce) begin
      unique case (move_state)
        move_idle: if (i_move_req) move_state <= move_write;
        move_write: move_state <= move_idle;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      move_dst_q <= 12'h000;
      move_data <= 8'h00;
    end else if (i_ce && !move_active && i_move_req) begin
      move_dst_q <= i_move_dst;
      move_data <= rd_value;
    end
  end

  // ---------------- checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  chk_pc_reset: assert property (disable iff (1'b0) $fell(i_srst) |-> o_pc == 21'h000000)
    else $error("fetch does not start at zero after reset");
  chk_vec_hi: assert property (i_ce && i_int_hi |=> o_pc == 21'h000008)
    else $error("high vector not taken");
  chk_vec_lo: assert property (i_ce && !i_int_hi && i_int_lo |=> o_pc == 21'h000018)
    else $error("low vector not taken");
  chk_zero_fill: assert property (i_ce && fetch_go && prog_route == route_zero |=> o_instr == 16'h0000)
    else $error("absent program space did not read zero");
  chk_ext_only: assert property (eff_mode == external_only_mode |-> !o_int_req)
    else $error("internal flash used in external-only mode");
  chk_boot_split: assert property (eff_mode == boot_block_mode && prog_req |->
    (o_int_req == (prog_addr <= 21'h0007ff)) && (o_ext_req == (prog_addr > 21'h0007ff)))
    else $error("boot block split wrong");
  chk_flash_top: assert property (eff_mode == internal_only_mode && prog_req && prog_addr > FLASH_LAST
    |-> !o_int_req && !o_ext_req)
    else $error("fetch above flash reached a memory");
  chk_no_bus: assert property (!HAS_EXT_BUS |-> !o_ext_req)
    else $error("external bus used without one");
  chk_access_hi: assert property (!i_dm_indirect && i_dm_use_access && i_dm_offset >= ACCESS_SPLIT
    |-> dm_addr[11:8] == 4'hf)
    else $error("upper access segment not in last bank");
  chk_move_two: assert property ((i_ce && i_move_req && !o_move_busy) ##1 i_ce
    |-> o_move_busy ##1 !o_move_busy)
    else $error("register move not two cycles");
  chk_unimpl_zero: assert property (i_ce && dm_go && !i_dm_we && !is_sfr && !is_gpr
    |=> o_dm_rdata == 8'h00)
    else $error("unimplemented data location not zero");
  chk_sfr_top: assert property (o_sfr_req |-> o_sfr_addr >= 12'hf60)
    else $error("special register port outside top region");
  chk_ack_pulse: assert property (i_ce && o_wb_ack |=> !o_wb_ack)
    else $error("ack held for two cycles");

  cov_ext_fetch: cover property (o_ext_req ##1 o_instr_valid);
  cov_move: cover property (i_move_req ##1 o_move_busy ##1 !o_move_busy);
  cov_tbl_rd: cover property (i_ce && i_tbl_rd && tbl_ptr[0]);
  cov_vector: cover property (i_ce && i_int_lo ##1 o_pc == 21'h000018);

endmodule // mem_map_decoder

// [ext_prog_mem.sv]
// behavioural external program memory on the decoder's external bus
module ext_prog_mem (
  // clock
  input wire logic i_core_clk,
  // bus from the decoder
  input wire logic i_req,
  input wire logic [20:0] i_addr,
  output logic [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last = 16'h0000;
  // an unaddressed bus shows the inverse of the last word, never a stale copy
  assign o_rdata = i_req ? (i_addr[16:1] ^ 16'ha5a5) : ~last;
  always_ff @(posedge i_core_clk) begin
    if (i_req) begin
      last <= o_rdata;
    end
  end
endmodule // ext_prog_mem

// [mem_map_decoder_bench.sv]
// self-checking bench for the memory map decoder
`include "mmd_map.svh"
module mem_map_decoder_bench import mmd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'h0, i_srst = 1'h1, i_ce = 1'h1, i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic i_fetch_step = 1'h0, i_pc_load = 1'h0, i_int_hi = 1'h0, i_int_lo = 1'h0, i_tbl_rd = 1'h0;
  logic i_tbl_wr = 1'h0, i_dm_req = 1'h0, i_dm_we = 1'h0, i_dm_indirect = 1'h0, i_dm_use_access = 1'h0;
  logic i_move_req = 1'h0;
  logic [1:0] i_mode_cfg = 2'h0, i_dm_ptr_sel = 2'h0;
  logic [3:0] i_wb_sel = 4'hf;
  logic [7:0] i_wb_adr = 8'h00, i_dm_offset = 8'h00, i_dm_wdata = 8'h00;
  logic [31:0] i_wb_dat = 32'h0;
  logic [20:0] i_pc_value = 21'h0;
  logic [11:0] i_move_src = 12'h0, i_move_dst = 12'h0;
  logic o_wb_ack, o_instr_valid, o_int_req, o_ext_req, o_prog_wr, o_move_busy, o_sfr_req, o_sfr_we;
  logic [7:0] o_dm_rdata, o_prog_wr_byte, o_sfr_wdata, i_sfr_rdata;
  logic [31:0] o_wb_dat;
  logic [20:0] o_pc, o_int_addr, o_ext_addr, o_prog_wr_addr;
  logic [15:0] o_instr, i_int_rdata, i_ext_rdata;
  logic [11:0] o_sfr_addr;
  int errors = 0, comparisons = 0;
  logic [19:0] sfr_last = 20'h0;
  // remembers the last special register write seen at a clock edge
  always @(posedge i_core_clk) begin
    if (o_sfr_we) begin
      sfr_last <= {o_sfr_addr, o_sfr_wdata};
    end
  end
  // smaller general area leaves an unimplemented gap below the special registers
  mem_map_decoder #(.GPR_BYTES(3840)) uut (.*);
  ext_prog_mem pm (.i_core_clk(i_core_clk), .i_req(o_ext_req), .i_addr(o_ext_addr), .o_rdata(i_ext_rdata));
  assign i_int_rdata = o_int_addr[16:1] ^ (o_int_req ? 16'h3c3c : 16'hc3c3);
  assign i_sfr_rdata = o_sfr_addr[7:0] ^ (o_sfr_req ? 8'hc3 : 8'h3c);
  initial begin
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] mode);
    @(posedge i_core_clk);
    i_srst <= 1'h1;
    i_mode_cfg <= mode;
    repeat (20) @(posedge i_core_clk);
    i_srst <= 1'h0;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge i_core_clk);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= wd;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_wb_ack !== 1'h1 && n < 50);
    rd = o_wb_dat;
    if (n >= 50) begin
      errors++;
      give_verdict;
    end
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
  endtask
  task automatic wbr(string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'h0, adr, 32'h0, rd);
    check(what, rd, exp);
  endtask
  task automatic dm(input logic we, ind, acc, input logic [1:0] ps, input logic [7:0] off, wd);
    @(posedge i_core_clk);
    i_dm_req <= 1'h1;
    i_dm_we <= we;
    i_dm_indirect <= ind;
    i_dm_use_access <= acc;
    i_dm_ptr_sel <= ps;
    i_dm_offset <= off;
    i_dm_wdata <= wd;
    @(posedge i_core_clk);
    i_dm_req <= 1'h0;
    #1;
  endtask
  function automatic route_t route_of(prog_mode_t m, logic [20:0] a);
    case (m)
      external_only_mode: return route_external;
      boot_block_mode: return a <= `BOOT_LAST ? route_internal : route_external;
      extended_internal_external_mode: return a <= `FLASH_LAST_64K ? route_internal : route_external;
      default: return a <= `FLASH_LAST_64K ? route_internal : route_zero;
    endcase
  endfunction
  task automatic fetch_at(input logic [20:0] a, input route_t r);
    logic [15:0] exp;
    exp = r == route_internal ? a[16:1] ^ 16'h3c3c : r == route_external ? a[16:1] ^ 16'ha5a5 : 16'h0;
    @(posedge i_core_clk);
    i_pc_load <= 1'h1;
    i_pc_value <= a;
    @(posedge i_core_clk);
    i_pc_load <= 1'h0;
    i_fetch_step <= 1'h1;
    #1;
    check("int req", o_int_req, r == route_internal);
    check("ext req", o_ext_req, r == route_external);
    if (r != route_zero) check("addr", r == route_external ? o_ext_addr : o_int_addr, a);
    @(posedge i_core_clk);
    i_fetch_step <= 1'h0;
    #1;
    check("instr", o_instr, exp);
    check("valid", o_instr_valid, 1'h1);
    check("pc step", o_pc, 21'(a + `INSTR_STEP));
  endtask
  task automatic test_reset;
    check("pc", o_pc, `RESET_VEC);
    wbr("bank sel", `REG_BANK_SEL, 32'h0);
    wbr("tbl ptr", `REG_TBL_PTR, 32'h0);
    wbr("unmapped", 8'h40, 32'h0);
    $display("reset test done");
  endtask
  task automatic test_modes;
    logic [20:0] addrs [5] = '{21'h0007fe, 21'h000800, 21'h00fffe, 21'h010000, 21'h1ffffe};
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0]);
      wbr("mode stat", `REG_MODE_STAT, {29'h0, 1'h1, m[1:0]});
      foreach (addrs[k]) fetch_at(addrs[k], route_of(prog_mode_t'(m[1:0]), addrs[k]));
    end
    $display("mode test done");
  endtask
  task automatic test_vectors;
    @(posedge i_core_clk);
    i_int_hi <= 1'h1;
    i_pc_load <= 1'h1;
    i_pc_value <= 21'h000100;
    @(posedge i_core_clk);
    i_int_hi <= 1'h0;
    i_pc_load <= 1'h0;
    i_int_lo <= 1'h1;
    #1;
    check("hi vector", o_pc, `INT_VEC_HI);
    @(posedge i_core_clk);
    i_int_lo <= 1'h0;
    #1;
    check("lo vector", o_pc, `INT_VEC_LO);
    $display("vector test done");
  endtask
  task automatic test_data;
    logic [31:0] rd;
    wb(1'h1, `REG_BANK_SEL, 32'hff, rd);
    wbr("bank sel", `REG_BANK_SEL, 32'h0f);
    wb(1'h1, `REG_BANK_SEL, 32'h5, rd);
    dm(1'h1, 1'h0, 1'h0, 2'h0, 8'h10, 8'h77);
    wb(1'h1, `REG_IND_PTR0, 32'h510, rd);
    wb(1'h1, `REG_BANK_SEL, 32'h2, rd);
    dm(1'h0, 1'h1, 1'h0, 2'h0, 8'h00, 8'h00);
    check("indirect", o_dm_rdata, 8'h77);
    dm(1'h1, 1'h0, 1'h1, 2'h0, 8'h20, 8'h44);
    wb(1'h1, `REG_IND_PTR0 + 8'h4, 32'h020, rd);
    dm(1'h0, 1'h1, 1'h0, 2'h1, 8'h00, 8'h00);
    check("access low", o_dm_rdata, 8'h44);
    dm(1'h0, 1'h0, 1'h1, 2'h0, 8'h70, 8'h00);
    check("access high", o_dm_rdata, 8'h70 ^ 8'hc3);
    dm(1'h1, 1'h0, 1'h1, 2'h0, 8'h80, 8'h5a);
    check("sfr write", sfr_last, {12'hf80, 8'h5a});
    wb(1'h1, `REG_IND_PTR0 + 8'h8, 32'hf20, rd);
    dm(1'h0, 1'h1, 1'h0, 2'h2, 8'h00, 8'h00);
    check("gap", o_dm_rdata, 8'h00);
    @(posedge i_core_clk);
    i_move_req <= 1'h1;
    i_move_src <= 12'h020;
    i_move_dst <= 12'h7ff;
    @(posedge i_core_clk);
    i_move_req <= 1'h0;
    #1;
    check("move busy", o_move_busy, 1'h1);
    @(posedge i_core_clk);
    #1;
    check("move done", o_move_busy, 1'h0);
    do_reset(2'h3);
    wb(1'h1, `REG_IND_PTR0, 32'h7ff, rd);
    dm(1'h0, 1'h1, 1'h0, 2'h0, 8'h00, 8'h00);
    check("moved kept", o_dm_rdata, 8'h44);
    $display("data test done");
  endtask
  task automatic test_table;
    logic [31:0] rd;
    logic [15:0] w;
    w = 16'h091a ^ 16'h3c3c;
    for (int p = 0; p < 2; p++) begin
      wb(1'h1, `REG_TBL_PTR, 32'h1234 + p, rd);
      @(posedge i_core_clk);
      i_tbl_rd <= 1'h1;
      @(posedge i_core_clk);
      i_tbl_rd <= 1'h0;
      wbr("tbl latch", `REG_TBL_LATCH, p ? w[15:8] : w[7:0]);
    end
    wb(1'h1, `REG_TBL_LATCH, 32'h9c, rd);
    @(posedge i_core_clk);
    i_tbl_wr <= 1'h1;
    @(posedge i_core_clk);
    i_tbl_wr <= 1'h0;
    #1;
    check("prog wr", o_prog_wr, 1'h1);
    check("wr addr", o_prog_wr_addr, 21'h1235);
    check("wr byte", o_prog_wr_byte, 8'h9c);
    $display("table test done");
  endtask
  task automatic test_freeze;
    logic [20:0] p;
    p = o_pc;
    @(posedge i_core_clk);
    i_ce <= 1'h0;
    i_fetch_step <= 1'h1;
    i_int_hi <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    i_ce <= 1'h1;
    i_fetch_step <= 1'h0;
    i_int_hi <= 1'h0;
    #1;
    check("frozen pc", o_pc, p);
    check("frozen valid", o_instr_valid, 1'h0);
    $display("freeze test done");
  endtask
  initial begin
    do_reset(2'h0);
    test_reset;
    test_modes;
    test_vectors;
    test_data;
    test_table;
    test_freeze;
    give_verdict;
  end
  initial begin
    repeat (50000) @(posedge i_core_clk);
    errors++;
    give_verdict;
  end
endmodule // mem_map_decoder_bench
